// *** inc/dtu_pkg.sv ***
package dtu_pkg;
   localparam int TIME_W = 64;
   localparam int NUM_PORTS = 4;
   localparam int CLK_FREQ_HZ = 20000000;
   localparam int STEP_NS = 1;
   localparam int CLK_PERIOD_NS = 1000000000 / CLK_FREQ_HZ;
   localparam int NOMINAL_INC_NS = CLK_PERIOD_NS / STEP_NS;
   localparam int INC_W = 8;
   localparam logic [63:0] EPOCH_ZERO = 64'h0000_0000_0000_0000;
   localparam logic [63:0] OFFSET_RST = 64'h0000_0000_0000_0000;
   localparam int DRIFT_W = 16;
   localparam logic [15:0] DRIFT_RST = 16'h0000;
   localparam int FILT_SHIFT = 2;
   typedef enum logic [1:0] {
      DTU_DRIFT_NONE,
      DTU_DRIFT_FAST,
      DTU_DRIFT_SLOW
   } dtu_drift_t;
endpackage

// *** inc/dtu_stamp_if.sv ***
`timescale 1ns/1ps
interface dtu_stamp_if #(parameter int TW = 64);
   logic [TW-1:0] local_time;
   logic arm;
   logic preamble;
   logic [TW-1:0] stamp;
   logic valid;
   modport owner (output local_time, output arm, output preamble, input stamp, input valid);
   modport capt (input local_time, input arm, input preamble, output stamp, output valid);
endinterface

// *** core/dtu_port_stamp.sv ***
`timescale 1ns/1ps
module dtu_port_stamp #(
   parameter int TW = 64
) (
   input wire logic clk_i,
   input wire logic rst_i,
   dtu_stamp_if.capt st
);
   logic [TW-1:0] stamp_q, stamp_d;
   logic valid_q, valid_d;
   logic armed_q, armed_d;
   logic pre_q, pre_d;
   always_comb begin
      stamp_d = stamp_q;
      valid_d = valid_q;
      armed_d = armed_q;
      pre_d = st.preamble;
      if (st.arm) begin
         armed_d = 1'b1;
         valid_d = 1'b0;
      end else if (armed_q && st.preamble && !pre_q) begin
         // first preamble bit only
         stamp_d = st.local_time;
         valid_d = 1'b1;
         armed_d = 1'b0;
      end
   end
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         stamp_q <= '0;
         valid_q <= 1'b0;
         armed_q <= 1'b0;
         pre_q <= 1'b0;
      end else begin
         stamp_q <= stamp_d;
         valid_q <= valid_d;
         armed_q <= armed_d;
         pre_q <= pre_d;
      end
   end
   assign st.stamp = stamp_q;
   assign st.valid = valid_q;
endmodule

// *** core/dtu_top.sv ***
`timescale 1ns/1ps
// Overview of operation
// - system time is a 64-bit count, one nanosecond per step.
// - zero means start of year 2000; master loads time on that epoch.
// - low 32 bits alone wrap in about 4.2 s and stay compatible.
// - system time copy equals local clock plus stored offset.
// - offset is added to local clock; running counter is never rewritten.
// - drift corrected by changing the local clock step rate.
// - local clock is captured when a measurement frame arrives.
// - devices with three or more ports keep local clock and stamps.
// - two-port devices may omit time features; treated as wire delay.
// - full device gives stamps, system time and control loop.
// - loop filter is resettable; master resets it before drift correction.
// - arrival time captured per port, up to four, at first preamble bit.
module dtu_top
   import dtu_pkg::*;
#(
   parameter int NPORTS = dtu_pkg::NUM_PORTS
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [dtu_pkg::TIME_W-1:0] offset_i,
   input wire logic offset_we_i,
   input wire logic [dtu_pkg::TIME_W-1:0] delay_i,
   input wire logic delay_we_i,
   input wire logic [dtu_pkg::TIME_W-1:0] diff_i,
   input wire logic diff_we_i,
   input wire logic filt_rst_i,
   input wire logic meas_arm_i,
   input wire logic [NPORTS-1:0] preamble_i,
   output logic [dtu_pkg::TIME_W-1:0] local_time_o,
   output logic [dtu_pkg::TIME_W-1:0] sys_time_o,
   output logic [31:0] sys_time_lo_o,
   output logic [NPORTS*dtu_pkg::TIME_W-1:0] rx_time_o,
   output logic [NPORTS-1:0] rx_valid_o,
   output logic [dtu_pkg::TIME_W-1:0] delay_o
);
   import dtu_pkg::*;
   logic [TIME_W-1:0] local_q, local_d;
   logic [TIME_W-1:0] sys_q, sys_d;
   logic [31:0] syslo_q, syslo_d;
   logic [TIME_W-1:0] offset_q, offset_d;
   logic [TIME_W-1:0] delay_q, delay_d;
   logic signed [DRIFT_W-1:0] filt_q, filt_d;
   logic [DRIFT_W-1:0] acc_q, acc_d;
   dtu_drift_t mode_q, mode_d;
   logic [NPORTS-1:0] p1_q, p2_q, p3_q;
   logic [NPORTS-1:0] pin_q, pin_d;
   logic [NPORTS*TIME_W-1:0] rx_q;
   logic [NPORTS-1:0] rxv_q;
   logic [NPORTS*TIME_W-1:0] rx_w;
   logic [NPORTS-1:0] rxv_w;
   logic [INC_W-1:0] inc;
   logic [TIME_W-1:0] next_local;
   logic [DRIFT_W:0] acc_sum;
   logic signed [DRIFT_W-1:0] diff_s;
   logic signed [DRIFT_W+1:0] filt_step;
   logic [NPORTS-1:0] p1_d, p2_d, p3_d;
   localparam logic signed [DRIFT_W-1:0] DIFF_MAX = {1'b0, {(DRIFT_W-1){1'b1}}};
   localparam logic signed [DRIFT_W-1:0] DIFF_MIN = {1'b1, {(DRIFT_W-1){1'b0}}};

   // pins pass three flops; change counts when second and third agree
   always_comb begin
      pin_d = pin_q;
      p1_d = preamble_i;
      p2_d = p1_q;
      p3_d = p2_q;
      for (int i = 0; i < NPORTS; i++) begin
         if (p2_q[i] == p3_q[i]) begin
            pin_d[i] = p3_q[i];
         end
      end
   end

   generate
      // built for any port count; a two-port build may simply leave them idle
      for (genvar g = 0; g < NPORTS; g++) begin : g_port
         dtu_stamp_if #(.TW(TIME_W)) st_if ();
         assign st_if.local_time = local_q;
         assign st_if.arm = meas_arm_i;
         assign st_if.preamble = pin_q[g];
         dtu_port_stamp #(.TW(TIME_W)) u_stamp (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .st(st_if.capt)
         );
         assign rx_w[g*TIME_W +: TIME_W] = st_if.stamp;
         assign rxv_w[g] = st_if.valid;
      end
   endgenerate

   // drift loop: filtered difference steers step size by one ns via accumulator
   always_comb begin
      filt_d = filt_q;
      mode_d = mode_q;
      acc_d = acc_q;
      filt_step = '0;
      acc_sum = '0;
      // clamp wide differences; a wrapped low word would steer the wrong way
      if (diff_i[TIME_W-1:DRIFT_W-1] == '0 || diff_i[TIME_W-1:DRIFT_W-1] == '1) begin
         diff_s = diff_i[DRIFT_W-1:0];
      end else if (diff_i[TIME_W-1]) begin
         diff_s = DIFF_MIN;
      end else begin
         diff_s = DIFF_MAX;
      end
      if (filt_rst_i) begin
         filt_d = DRIFT_RST;
         mode_d = DTU_DRIFT_NONE;
         acc_d = '0;
      end else begin
         if (diff_we_i) begin
            // two guard bits so the difference of two extremes cannot wrap
            filt_step = (DRIFT_W+2)'(diff_s) - (DRIFT_W+2)'(filt_q);
            filt_d = filt_q + DRIFT_W'(filt_step >>> FILT_SHIFT);
         end
         // mode follows the new filter value so direction and carry agree
         if (filt_d > 0) begin
            mode_d = DTU_DRIFT_SLOW; // local ahead of system: slow down
         end else if (filt_d < 0) begin
            mode_d = DTU_DRIFT_FAST;
         end else begin
            mode_d = DTU_DRIFT_NONE;
         end
         acc_sum = {1'b0, acc_q} + {1'b0, (filt_q < 0) ? DRIFT_W'(-filt_q) : filt_q};
         acc_d = acc_sum[DRIFT_W-1:0];
      end
   end

   always_comb begin
      inc = INC_W'(NOMINAL_INC_NS);
      case (mode_q)
         DTU_DRIFT_NONE: inc = INC_W'(NOMINAL_INC_NS);
         DTU_DRIFT_FAST: begin
            if (acc_sum[DRIFT_W]) begin
               inc = INC_W'(NOMINAL_INC_NS + 1);
            end
         end
         DTU_DRIFT_SLOW: begin
            if (acc_sum[DRIFT_W]) begin
               inc = INC_W'(NOMINAL_INC_NS - 1);
            end
         end
         default: inc = INC_W'(NOMINAL_INC_NS);
      endcase
   end

   always_comb begin
      next_local = local_q + TIME_W'(inc);
      local_d = next_local;
      offset_d = offset_we_i ? offset_i : offset_q;
      delay_d = delay_we_i ? delay_i : delay_q;
      // sum from the same next values keeps both outputs on one instant
      sys_d = next_local + offset_d;
      syslo_d = sys_d[31:0];
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         local_q <= '0;
         sys_q <= EPOCH_ZERO;
         syslo_q <= '0;
         offset_q <= OFFSET_RST;
         delay_q <= '0;
      end else begin
         local_q <= local_d;
         sys_q <= sys_d;
         syslo_q <= syslo_d;
         offset_q <= offset_d;
         delay_q <= delay_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         filt_q <= DRIFT_RST;
         acc_q <= '0;
         mode_q <= DTU_DRIFT_NONE;
      end else begin
         filt_q <= filt_d;
         acc_q <= acc_d;
         mode_q <= mode_d;
      end
   end

   // only stage two reads stage one; later logic sees the filtered level
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         p1_q <= '0;
         p2_q <= '0;
         p3_q <= '0;
         pin_q <= '0;
      end else begin
         p1_q <= p1_d;
         p2_q <= p2_d;
         p3_q <= p3_d;
         pin_q <= pin_d;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_q <= '0;
         rxv_q <= '0;
      end else begin
         rx_q <= rx_w;
         rxv_q <= rxv_w;
      end
   end

   assign local_time_o = local_q;
   assign sys_time_o = sys_q;
   assign sys_time_lo_o = syslo_q;
   assign rx_time_o = rx_q;
   assign rx_valid_o = rxv_q;
   assign delay_o = delay_q;
endmodule

// *** testbench/dtu_chk.sv ***
`timescale 1ns/1ps
module dtu_chk #(parameter int NPORTS = 4) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [63:0] offset_i,
   input wire logic offset_we_i,
   input wire logic [63:0] delay_i,
   input wire logic delay_we_i,
   input wire logic meas_arm_i,
   input wire logic [63:0] local_time_o,
   input wire logic [63:0] sys_time_o,
   input wire logic [31:0] sys_time_lo_o,
   input wire logic [NPORTS*64-1:0] rx_time_o,
   input wire logic [NPORTS-1:0] rx_valid_o,
   input wire logic [63:0] delay_o
);
   logic [63:0] off_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) off_q <= '0;
      else if (offset_we_i) off_q <= offset_i;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   a_sys_sum: assert property (sys_time_o == local_time_o + off_q)
      else $error("system time is not local time plus offset");
   a_lo_copy: assert property (sys_time_lo_o == sys_time_o[31:0])
      else $error("low word differs from system time");
   a_step_rate: assert property (!$past(rst_i) |->
      (local_time_o - $past(local_time_o)) inside {[49:51]}) else $error("bad clock step");
   a_delay_load: assert property (delay_we_i |=> delay_o == $past(delay_i))
      else $error("delay not loaded");
   a_arm_clears: assert property (meas_arm_i |-> ##2 rx_valid_o == '0)
      else $error("arm did not clear valid");
   a_valid_sticky: assert property (!meas_arm_i && !$past(meas_arm_i) &&
      !$past(meas_arm_i, 2) |=> (rx_valid_o & $past(rx_valid_o)) == $past(rx_valid_o))
      else $error("valid dropped without arm");
   a_stamp_hold: assert property (rx_valid_o[0] [*3] |-> $stable(rx_time_o[63:0]))
      else $error("stamp changed while valid");
   a_stamp_recent: assert property ($rose(rx_valid_o[0]) |-> ##[0:1]
      (local_time_o - rx_time_o[63:0] < 64'd500)) else $error("stamp not recent");
endmodule
bind dtu_top dtu_chk #(.NPORTS(NPORTS)) dtu_chk_i (.clk_i(clk_i), .rst_i(rst_i),
   .offset_i(offset_i), .offset_we_i(offset_we_i), .delay_i(delay_i),
   .delay_we_i(delay_we_i), .meas_arm_i(meas_arm_i), .local_time_o(local_time_o),
   .sys_time_o(sys_time_o), .sys_time_lo_o(sys_time_lo_o), .rx_time_o(rx_time_o),
   .rx_valid_o(rx_valid_o), .delay_o(delay_o));

// *** testbench/dtu_net_master.sv ***
`timescale 1ns/1ps
module dtu_net_master (
   input wire logic clk_i,
   output logic [63:0] val_o,
   output logic [4:0] we_o,
   output logic [3:0] preamble_o
);
   initial begin
      val_o = '0;
      we_o = '0;
      preamble_o = '0;
   end
   // k: 0 offset, 1 delay, 2 drift diff, 3 filter reset, 4 arm
   task automatic wr(input int k, input logic [63:0] v);
      val_o = v;
      we_o = 5'h1 << k;
      @(negedge clk_i);
      val_o = ~v; // released bus must not look like a held word
      we_o = '0;
      @(negedge clk_i);
   endtask
   task automatic frame(input logic [3:0] m);
      preamble_o = m;
      repeat (10) @(negedge clk_i);
      preamble_o = '0;
      repeat (4) @(negedge clk_i);
   endtask
endmodule

// *** testbench/dtu_tb_top.sv ***
`timescale 1ns/1ps
module dtu_tb_top;
   import dtu_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [63:0] val, lt, sy, dl, t0;
   logic [31:0] lo, seed = 32'h2a49;
   logic [255:0] rt, keep;
   logic [4:0] we;
   logic [3:0] pre, rv, mk;
   int error_cnt = 0;
   int n_compared = 0;
   dtu_net_master dtu_net_master_i (.clk_i(clk_i), .val_o(val), .we_o(we), .preamble_o(pre));
   dtu_top dtu_top_i (.clk_i(clk_i), .rst_i(rst_i), .offset_i(val), .offset_we_i(we[0]),
      .delay_i(val), .delay_we_i(we[1]), .diff_i(val), .diff_we_i(we[2]), .filt_rst_i(we[3]),
      .meas_arm_i(we[4]), .preamble_i(pre), .local_time_o(lt), .sys_time_o(sy),
      .sys_time_lo_o(lo), .rx_time_o(rt), .rx_valid_o(rv), .delay_o(dl));
   function automatic logic [63:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return {~seed, seed};
   endfunction
   function automatic logic [63:0] ns(input int n);
      return 64'(n) * NOMINAL_INC_NS;
   endfunction
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial forever #25 clk_i = ~clk_i;
   initial begin
      #1000000;
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (12) @(negedge clk_i);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk(lt, ns(1));
      chk(sy, ns(1));
      t0 = lt;
      dtu_net_master_i.wr(0, EPOCH_ZERO - lt - ns(1));
      chk(sy, EPOCH_ZERO + ns(1));
      chk(lt, t0 + ns(2));
      repeat (20) begin
         t0 = rnd();
         dtu_net_master_i.wr(0, t0);
         chk(sy, lt + t0);
         chk(lo, sy[31:0]);
         dtu_net_master_i.wr(1, ~t0);
         chk(dl, ~t0);
      end
      for (int i = 0; i < 4; i++) begin
         mk = i ? 4'(rnd()) : 4'hf;
         dtu_net_master_i.wr(4, '0);
         @(negedge clk_i);
         chk(rv, '0);
         t0 = lt;
         dtu_net_master_i.frame(mk);
         chk(rv, mk);
         for (int g = 0; g < 4; g++)
            if (mk[g]) chk(rt[g*64+:64] - t0 - ns(1) < ns(8), 1'b1);
         keep = rt;
         dtu_net_master_i.frame(mk);
         chk(rt == keep, 1'b1);
      end
      for (int s = 0; s < 3; s++) begin
         dtu_net_master_i.wr(3, '0);
         t0 = lt;
         repeat (100) @(negedge clk_i);
         chk(lt - t0, ns(100));
         // third pass: wide positive difference whose low word alone looks negative
         t0 = (s == 1) ? 64'hffff_ffff_ffff_c000 : (s == 2) ? 64'h1_8000 : 64'h4000;
         repeat (20) dtu_net_master_i.wr(2, t0);
         t0 = lt;
         repeat (1000) @(negedge clk_i);
         chk(lt - t0 > ns(1000), s == 1);
         chk(lt - t0 == ns(1000), 1'b0);
      end
      rst_i = 1'b1;
      @(negedge clk_i);
      chk(lt | sy | dl, '0);
      chk(rv, '0);
      rst_i = 1'b0;
      @(negedge clk_i);
      chk(lt, ns(1));
      chk(sy, ns(1) + OFFSET_RST);
      conclude();
   end
endmodule
